//--- nvspi_pkg.sv
/*
 * constants of the serial memory slave: geometry, commands, status layout,
 * protection bounds and command states.
 * assumes nothing of its surroundings; compiled before every other file.
 */

package nvspi_pkg;

    // =====================================================================
    // array geometry
    localparam int ADDR_W = 14;
    localparam int BYTE_W = 8;
    localparam int MEM_DEPTH = 1 << ADDR_W;
    localparam int ADDR_HI_W = ADDR_W - BYTE_W;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 14'h0001;

    // =====================================================================
    // serial bit counter
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_STEP = 3'h1;
    localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;

    // =====================================================================
    // command codes
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_FSTRD = 8'h0b;
    localparam logic [7:0] OP_RDID = 8'h9f;

    // =====================================================================
    // status byte layout
    localparam int ST_GUARD = 7;
    localparam int ST_BP_HI = 3;
    localparam int ST_BP_LO = 2;
    localparam int ST_WEL = 1;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // =====================================================================
    // block protection
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [ADDR_W-1:0] QUARTER_BASE = 14'h3000;
    localparam logic [ADDR_W-1:0] HALF_BASE = 14'h2000;

    // =====================================================================
    // identification value, arbitrary neutral bytes
    localparam int ID_BYTES = 3;
    localparam int ID_IDX_W = 2;
    localparam logic [ID_IDX_W-1:0] ID_IDX_ZERO = 2'h0;
    localparam logic [ID_IDX_W-1:0] ID_IDX_STEP = 2'h1;
    localparam logic [ID_IDX_W-1:0] ID_IDX_LAST = 2'h2;
    localparam logic [ID_BYTES*8-1:0] ID_DEFAULT = 24'h5a_a5c3;

    // =====================================================================
    // command states
    typedef enum logic [3:0] {
        ST_OPCODE = 4'h0,
        ST_ADDR_HI = 4'h1,
        ST_ADDR_LO = 4'h2,
        ST_DUMMY = 4'h3,
        ST_READ = 4'h4,
        ST_WRITE = 4'h5,
        ST_RDSR = 4'h6,
        ST_WRSR = 4'h7,
        ST_RDID = 4'h8,
        ST_IGNORE = 4'h9
    } cmd_state_t;

endpackage

//--- level_sync.sv
/*
 * two flip-flop synchroniser for a bundle of independent levels.
 * assumes each bit changes slowly against clk and bits are not related.
 */
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // =====================================================================
    // first stage feeds only the second stage
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

//--- nv_memory_spi_slave.sv
/*
 * serial peripheral slave front end of a 16K x 8 nonvolatile byte memory,
 * with command decode, status byte, block protection, identification read,
 * pause input and a small monitor port in the system clock domain.
 * assumes: spi_clk is the master's clock (mode 0 or 3), cs_n/si/hold_n/wp_n
 * are pins of that link; ref_clk is an unrelated system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module nv_memory_spi_slave #(
    parameter logic [nvspi_pkg::ID_BYTES*8-1:0] ID_VALUE = nvspi_pkg::ID_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic spi_clk,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic sel_active,
    output logic held,
    output logic wr_strobe,
    output logic [nvspi_pkg::ADDR_W-1:0] wr_addr,
    output logic [nvspi_pkg::BYTE_W-1:0] wr_data,
    output logic [nvspi_pkg::BYTE_W-1:0] status_out
);

    // =====================================================================
    // link domain declarations
    logic frame_rst_n;
    logic [nvspi_pkg::CNT_W-1:0] bit_cnt_q;
    logic [nvspi_pkg::BYTE_W-2:0] shift_q;
    nvspi_pkg::cmd_state_t state_q;
    logic [7:0] cmd_q;
    logic [nvspi_pkg::ADDR_W-1:0] addr_q;
    logic wr_ok_q;
    logic [nvspi_pkg::ID_IDX_W-1:0] id_idx_q;
    logic [nvspi_pkg::BYTE_W-1:0] tx_q;
    logic so_q;
    logic so_oe_q;
    logic guard_pin_enable_q;
    logic [1:0] bp_q;
    logic wel_q;
    logic [nvspi_pkg::BYTE_W-1:0] mem [nvspi_pkg::MEM_DEPTH];
    logic evt_toggle_q;
    logic [nvspi_pkg::ADDR_W-1:0] evt_addr_q;
    logic [nvspi_pkg::BYTE_W-1:0] evt_data_q;
    logic [nvspi_pkg::BYTE_W-1:0] rx_byte;
    logic byte_done;
    logic [nvspi_pkg::ADDR_W-1:0] addr_full;
    logic [nvspi_pkg::BYTE_W-1:0] status_byte;
    logic addr_locked;
    logic mem_we;
    logic status_chg;
    logic talking;

    // =====================================================================
    // frame control

    // select high ends the frame, but not while paused
    assign frame_rst_n = nrst & ~(cs_n & hold_n);

    // byte in flight, msb first; done on eighth rising edge if not paused
    assign rx_byte = {shift_q, si};
    assign byte_done = hold_n & (bit_cnt_q == nvspi_pkg::LAST_BIT);
    // upper two address bits of the first byte are dropped earlier
    assign addr_full = {addr_q[nvspi_pkg::ADDR_W-1:nvspi_pkg::BYTE_W], rx_byte};

    // status byte assembled from its fields, unused bits read zero
    always_comb begin
        status_byte = nvspi_pkg::STATUS_RST;
        status_byte[nvspi_pkg::ST_GUARD] = guard_pin_enable_q;
        status_byte[nvspi_pkg::ST_BP_HI:nvspi_pkg::ST_BP_LO] = bp_q;
        status_byte[nvspi_pkg::ST_WEL] = wel_q;
    end

    // block protection bounds on the current write address
    always_comb begin
        unique case (bp_q)
            nvspi_pkg::BP_NONE: addr_locked = 1'b0;
            nvspi_pkg::BP_QUARTER: addr_locked = (addr_q >= nvspi_pkg::QUARTER_BASE);
            nvspi_pkg::BP_HALF: addr_locked = (addr_q >= nvspi_pkg::HALF_BASE);
            default: addr_locked = 1'b1;
        endcase
    end

    // array write on the eighth data bit, only if the frame was allowed
    assign mem_we = byte_done & (state_q == nvspi_pkg::ST_WRITE) & wr_ok_q & ~addr_locked;

    // any change of the persistent status byte
    assign status_chg = byte_done & (
        ((state_q == nvspi_pkg::ST_OPCODE) &
            ((rx_byte == nvspi_pkg::OP_WREN) | (rx_byte == nvspi_pkg::OP_WRDI) |
             (rx_byte == nvspi_pkg::OP_WRITE) | (rx_byte == nvspi_pkg::OP_WRSR))) |
        ((state_q == nvspi_pkg::ST_WRSR) & wr_ok_q));

    // states in which the slave answers on the output
    assign talking = (state_q == nvspi_pkg::ST_READ) | (state_q == nvspi_pkg::ST_RDSR) |
                     (state_q == nvspi_pkg::ST_RDID);

    // =====================================================================
    // identification bytes, most significant first, cycling
    function automatic logic [nvspi_pkg::BYTE_W-1:0] id_byte(
        input logic [nvspi_pkg::ID_IDX_W-1:0] idx
    );
        int pos;
        pos = (nvspi_pkg::ID_BYTES - 1 - int'(idx)) * nvspi_pkg::BYTE_W;
        id_byte = ID_VALUE[pos +: nvspi_pkg::BYTE_W];
    endfunction

    // =====================================================================
    // receive shifter and bit counter, rising edges only
    always_ff @(posedge spi_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt_q <= nvspi_pkg::CNT_ZERO;
            shift_q <= '0;
        end else if (hold_n) begin
            // no mode bit needed: counting starts at the first rising edge
            bit_cnt_q <= bit_cnt_q + nvspi_pkg::CNT_STEP;
            shift_q <= rx_byte[nvspi_pkg::BYTE_W-2:0];
        end
    end

    // =====================================================================
    // command decode and address sequencing
    always_ff @(posedge spi_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            state_q <= nvspi_pkg::ST_OPCODE;
            cmd_q <= '0;
            addr_q <= '0;
            wr_ok_q <= 1'b0;
            id_idx_q <= nvspi_pkg::ID_IDX_ZERO;
            tx_q <= '0;
        end else if (byte_done) begin
            unique case (state_q)
                nvspi_pkg::ST_OPCODE: begin
                    // first byte of every selection is the command
                    cmd_q <= rx_byte;
                    unique case (rx_byte)
                        nvspi_pkg::OP_RDSR: begin
                            state_q <= nvspi_pkg::ST_RDSR;
                            tx_q <= status_byte;
                        end
                        nvspi_pkg::OP_WRSR: begin
                            state_q <= nvspi_pkg::ST_WRSR;
                            // pin guard only bites with the guard bit set
                            wr_ok_q <= wel_q & ~(guard_pin_enable_q & ~wp_n);
                        end
                        nvspi_pkg::OP_READ, nvspi_pkg::OP_FSTRD: begin
                            state_q <= nvspi_pkg::ST_ADDR_HI;
                        end
                        nvspi_pkg::OP_WRITE: begin
                            state_q <= nvspi_pkg::ST_ADDR_HI;
                            wr_ok_q <= wel_q;
                        end
                        nvspi_pkg::OP_RDID: begin
                            state_q <= nvspi_pkg::ST_RDID;
                            tx_q <= id_byte(nvspi_pkg::ID_IDX_ZERO);
                            id_idx_q <= nvspi_pkg::ID_IDX_STEP;
                        end
                        // latch commands and unknown codes: deaf until reselect
                        default: state_q <= nvspi_pkg::ST_IGNORE;
                    endcase
                end
                nvspi_pkg::ST_ADDR_HI: begin
                    // top two bits of the first address byte are don't care
                    addr_q[nvspi_pkg::ADDR_W-1:nvspi_pkg::BYTE_W] <=
                        rx_byte[nvspi_pkg::ADDR_HI_W-1:0];
                    state_q <= nvspi_pkg::ST_ADDR_LO;
                end
                nvspi_pkg::ST_ADDR_LO: begin
                    if (cmd_q == nvspi_pkg::OP_READ) begin
                        // fetch at once so bit 7 is ready for the next fall
                        tx_q <= mem[addr_full];
                        addr_q <= addr_full + nvspi_pkg::ADDR_STEP;
                        state_q <= nvspi_pkg::ST_READ;
                    end else if (cmd_q == nvspi_pkg::OP_FSTRD) begin
                        addr_q <= addr_full;
                        state_q <= nvspi_pkg::ST_DUMMY;
                    end else begin
                        addr_q <= addr_full;
                        state_q <= nvspi_pkg::ST_WRITE;
                    end
                end
                nvspi_pkg::ST_DUMMY, nvspi_pkg::ST_READ: begin
                    // fast read spends one dummy byte, then streams like read
                    tx_q <= mem[addr_q];
                    addr_q <= addr_q + nvspi_pkg::ADDR_STEP;
                    state_q <= nvspi_pkg::ST_READ;
                end
                nvspi_pkg::ST_WRITE: begin
                    // 14-bit address rolls from the last byte to zero
                    addr_q <= addr_q + nvspi_pkg::ADDR_STEP;
                end
                nvspi_pkg::ST_RDSR: begin
                    tx_q <= status_byte;
                end
                nvspi_pkg::ST_RDID: begin
                    tx_q <= id_byte(id_idx_q);
                    if (id_idx_q == nvspi_pkg::ID_IDX_LAST) begin
                        id_idx_q <= nvspi_pkg::ID_IDX_ZERO;
                    end else begin
                        id_idx_q <= id_idx_q + nvspi_pkg::ID_IDX_STEP;
                    end
                end
                nvspi_pkg::ST_WRSR: begin
                    // one status byte per selection, the rest is ignored
                    state_q <= nvspi_pkg::ST_IGNORE;
                end
                nvspi_pkg::ST_IGNORE: begin
                    state_q <= nvspi_pkg::ST_IGNORE;
                end
                default: state_q <= nvspi_pkg::ST_IGNORE;
            endcase
        end
    end

    // =====================================================================
    // persistent status bits, survive deselection
    always_ff @(posedge spi_clk or negedge nrst) begin
        if (!nrst) begin
            guard_pin_enable_q <= 1'b0;
            bp_q <= nvspi_pkg::BP_NONE;
            wel_q <= 1'b0;
        end else if (byte_done && state_q == nvspi_pkg::ST_OPCODE) begin
            // latch drops as soon as a write command is taken
            if (rx_byte == nvspi_pkg::OP_WREN) begin
                wel_q <= 1'b1;
            end else if (rx_byte == nvspi_pkg::OP_WRDI || rx_byte == nvspi_pkg::OP_WRITE ||
                         rx_byte == nvspi_pkg::OP_WRSR) begin
                wel_q <= 1'b0;
            end
        end else if (byte_done && state_q == nvspi_pkg::ST_WRSR && wr_ok_q) begin
            guard_pin_enable_q <= rx_byte[nvspi_pkg::ST_GUARD];
            bp_q <= rx_byte[nvspi_pkg::ST_BP_HI:nvspi_pkg::ST_BP_LO];
        end
    end

    // =====================================================================
    // storage array, flip-flops; no reset since contents are nonvolatile
    always_ff @(posedge spi_clk) begin
        if (mem_we) begin
            mem[addr_q] <= rx_byte;
        end
    end

    // =====================================================================
    // monitor event, toggled per array write or status change; copies held until the next write
    always_ff @(posedge spi_clk or negedge nrst) begin
        if (!nrst) begin
            evt_toggle_q <= 1'b0;
            evt_addr_q <= '0;
            evt_data_q <= '0;
        end else if (mem_we) begin
            evt_toggle_q <= ~evt_toggle_q;
            evt_addr_q <= addr_q;
            evt_data_q <= rx_byte;
        end else if (status_chg) begin
            evt_toggle_q <= ~evt_toggle_q;
        end
    end

    // =====================================================================
    // output shifter, falling edges only
    always_ff @(negedge spi_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
        end else if (hold_n) begin
            so_q <= tx_q[nvspi_pkg::LAST_BIT - bit_cnt_q];
            so_oe_q <= talking;
        end
    end

    // pause and deselect float the pin at once, without a clock edge
    assign so = so_q;
    assign so_oe = so_oe_q & hold_n & ~cs_n;

    // =====================================================================
    // system clock domain monitor
    logic [2:0] sync_out;
    logic evt_seen_q;
    logic sel_active_q;
    logic held_q;
    logic wr_strobe_q;
    logic [nvspi_pkg::ADDR_W-1:0] wr_addr_q;
    logic [nvspi_pkg::BYTE_W-1:0] wr_data_q;
    logic [nvspi_pkg::BYTE_W-1:0] status_out_q;

    level_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(ref_clk),
        .nrst(nrst),
        .async_in({evt_toggle_q, ~hold_n, ~cs_n}),
        .sync_out(sync_out)
    );

    // select and pause levels for the system side
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sel_active_q <= 1'b0;
            held_q <= 1'b0;
        end else begin
            sel_active_q <= sync_out[0];
            held_q <= sync_out[1];
        end
    end

    // event edge: the copies are quiet by then, as the next event is at
    // least eight link clocks away; a faster link than that would race
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            evt_seen_q <= 1'b0;
            wr_strobe_q <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= '0;
            status_out_q <= nvspi_pkg::STATUS_RST;
        end else begin
            evt_seen_q <= sync_out[2];
            wr_strobe_q <= 1'b0;
            if (sync_out[2] != evt_seen_q) begin
                wr_strobe_q <= 1'b1;
                wr_addr_q <= evt_addr_q;
                wr_data_q <= evt_data_q;
                status_out_q <= status_byte;
            end
        end
    end

    assign sel_active = sel_active_q;
    assign held = held_q;
    assign wr_strobe = wr_strobe_q;
    assign wr_addr = wr_addr_q;
    assign wr_data = wr_data_q;
    assign status_out = status_out_q;

endmodule

`default_nettype wire

//--- nv_memory_spi_slave_properties.sv
/*
 * concurrent checks on the ports of the serial memory slave, bound to it.
 * assumes ref_clk is the monitor clock and link pins change slowly against it.
 */
`timescale 1ns/1ps
`default_nettype none

module nv_memory_spi_slave_properties (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic spi_clk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic sel_active,
    input wire logic held,
    input wire logic wr_strobe,
    input wire logic [nvspi_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [nvspi_pkg::BYTE_W-1:0] wr_data,
    input wire logic [nvspi_pkg::BYTE_W-1:0] status_out
);
    // =====================================================================
    // all checks run on the monitor clock
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // select views follow the pin within the crossing latency
    sel_on_a: assert property ($fell(cs_n) |-> ##[2:4] sel_active) else $error("select late");
    sel_off_a: assert property ($rose(cs_n) && hold_n |-> ##[2:4] !sel_active)
        else $error("deselect late");
    oe_cs_a: assert property (cs_n |-> !so_oe) else $error("output driven in standby");
    oe_hold_a: assert property (!hold_n |-> !so_oe) else $error("output driven in pause");
    held_on_a: assert property ($fell(hold_n) |-> ##[2:4] held) else $error("pause view late");
    strobe_one_a: assert property (wr_strobe |=> !wr_strobe) else $error("strobe too long");
    // a write event under quarter protection never lands in the top quarter
    quarter_lock_a: assert property (wr_strobe && status_out[3:2] == nvspi_pkg::BP_QUARTER
        |-> wr_addr < nvspi_pkg::QUARTER_BASE) else $error("write in locked quarter");
    // wel is left out: it may change while the pin guards the rest
    guard_pin_a: assert property (!wp_n && !$past(wp_n, 6) && $past(status_out[7])
        |-> $stable(status_out[7:2])) else $error("status written while guarded");
endmodule

bind nv_memory_spi_slave nv_memory_spi_slave_properties nv_memory_spi_slave_properties_i (.*);

`default_nettype wire

//--- nv_spi_master.sv
/*
 * behavioural serial master driving the memory slave's link pins.
 * assumes one task call at a time from the bench; half period 80 ns.
 */
`timescale 1ns/1ps
`default_nettype none

module nv_spi_master (
    output logic spi_clk,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    input wire logic so,
    input wire logic so_oe
);
    // =====================================================================
    // link pins; a released output reads as a toggling pattern
    logic idle_hi = 1'b0;
    logic tog = 1'b0;
    logic miso;
    assign miso = so_oe ? so : tog;
    initial begin
        spi_clk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    // clock parks at the mode's idle level before select falls
    task automatic open_frame(input logic mode3);
        idle_hi = mode3;
        spi_clk = mode3;
        #37;
        cs_n = 1'b0;
        #80;
    endtask
    // drive while low, sample at the rise, msb first
    task automatic xfer(input int nbits, input logic [7:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            spi_clk = 1'b0;
            si = tx[i];
            tog = ~tog;
            #80;
            spi_clk = 1'b1;
            rx[i] = miso;
            #80;
        end
    endtask
    task automatic close_frame();
        spi_clk = idle_hi;
        #80;
        cs_n = 1'b1;
        si = ~si;
        #300;
    endtask
    // pause only with the clock low; clock and select wiggle meanwhile
    task automatic pause_frame();
        spi_clk = 1'b0;
        #40;
        hold_n = 1'b0;
        repeat (3) begin
            #80 spi_clk = 1'b1;
            #80 spi_clk = 1'b0;
        end
        cs_n = 1'b1;
        #400 cs_n = 1'b0;
        #80 hold_n = 1'b1;
        #40;
    endtask
endmodule

`default_nettype wire

//--- serial_nv_memory_spi_slave_bench.sv
/*
 * self-checking bench: master model on the link, byte model of array and status.
 * assumes the design and its checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_nv_memory_spi_slave_bench;
    // =====================================================================
    // clocks, pins and model state
    logic ref_clk, nrst, wp_n, spi_clk, cs_n, si, so, so_oe, hold_n, oe_seen;
    logic sel_active, held, wr_strobe;
    logic [13:0] wr_addr;
    logic [7:0] wr_data, status_out, st_m, last_d, r;
    logic [7:0] mem_m [int];
    logic wel_m = 1'b0;
    int seed = 32'he079;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    nv_memory_spi_slave nv_memory_spi_slave_i (.ref_clk(ref_clk), .nrst(nrst),
        .spi_clk(spi_clk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .hold_n(hold_n),
        .wp_n(wp_n), .sel_active(sel_active), .held(held), .wr_strobe(wr_strobe),
        .wr_addr(wr_addr), .wr_data(wr_data), .status_out(status_out));
    nv_spi_master nv_spi_master_i (.spi_clk(spi_clk), .cs_n(cs_n), .si(si), .hold_n(hold_n),
        .so(so), .so_oe(so_oe));
    // timeout ceiling, about twenty times the traffic
    always @(posedge ref_clk) begin
        cyc++;
        oe_seen <= oe_seen | (so_oe === 1'b1);
        if (cyc == 30000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic x8(input logic [7:0] v);
        nv_spi_master_i.xfer(8, v, r);
    endtask
    task automatic cl();
        nv_spi_master_i.close_frame();
    endtask
    // opcode opens every frame; WREN and WRDI latch effects modelled here
    task automatic cmd(input logic mode3, input logic [7:0] op);
        nv_spi_master_i.open_frame(mode3);
        x8(op);
        if (op == nvspi_pkg::OP_WREN) wel_m = 1'b1;
        if (op == nvspi_pkg::OP_WRDI) wel_m = 1'b0;
    endtask
    task automatic one(input logic [7:0] op);
        cmd(1'b0, op);
        cl();
    endtask
    function automatic logic locked(input logic [13:0] p);
        return st_m[3:2] == 2'h3 || (st_m[3:2] == 2'h2 && p >= nvspi_pkg::HALF_BASE)
            || (st_m[3:2] == 2'h1 && p >= nvspi_pkg::QUARTER_BASE);
    endfunction
    task automatic wr(input logic [15:0] a, input int n);
        logic [7:0] d;
        logic [13:0] p;
        logic ok;
        p = a[13:0];
        ok = wel_m;
        cmd(1'b0, nvspi_pkg::OP_WRITE);
        wel_m = 1'b0;
        x8(a[15:8]);
        x8(a[7:0]);
        for (int k = 0; k < n; k++) begin
            d = $random(seed);
            x8(d);
            if (ok && !locked(p)) begin
                mem_m[p] = d;
                last_d = d;
            end
            p = p + 14'h0001;
        end
        cl();
        repeat (4) @(posedge ref_clk);
        chk(wr_data, last_d);
    endtask
    task automatic rd(input logic m3, input logic [7:0] op, input logic [15:0] a, input int n,
            input logic pz);
        logic [13:0] p;
        p = a[13:0];
        cmd(m3, op);
        x8(a[15:8]);
        x8(a[7:0]);
        if (op == nvspi_pkg::OP_FSTRD) x8(8'h00);
        if (pz) nv_spi_master_i.pause_frame();
        for (int k = 0; k < n; k++) begin
            x8($random(seed));
            if (mem_m.exists(p)) chk(r, mem_m[p]);
            p = p + 14'h0001;
        end
        cl();
    endtask
    task automatic wrsr(input logic [7:0] v);
        logic ok;
        ok = wel_m && !(st_m[7] && !wp_n);
        cmd(1'b0, nvspi_pkg::OP_WRSR);
        wel_m = 1'b0;
        x8(v);
        cl();
        if (ok) st_m = v & 8'h8c;
        cmd(1'b0, nvspi_pkg::OP_RDSR);
        x8(8'h00);
        cl();
        chk(r, st_m | {6'h00, wel_m, 1'b0});
    endtask
    // =====================================================================
    // main sequence
    initial begin
        nrst = 1'b0;
        wp_n = 1'b1;
        oe_seen = 1'b0;
        st_m = 8'h00;
        last_d = 8'h00;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        one(nvspi_pkg::OP_WREN);
        wr(16'hffff, 2);
        rd(1'b0, nvspi_pkg::OP_READ, 16'h3fff, 2, 1'b0);
        rd(1'b1, nvspi_pkg::OP_FSTRD, 16'hffff, 2, 1'b0);
        wr(16'h0000, 1);
        one(nvspi_pkg::OP_WREN);
        one(nvspi_pkg::OP_WRDI);
        wr(16'h0000, 1);
        rd(1'b0, nvspi_pkg::OP_READ, 16'h0000, 1, 1'b0);
        one(nvspi_pkg::OP_WREN);
        wrsr(8'h84);
        one(nvspi_pkg::OP_WREN);
        wr(16'h2ffe, 4);
        rd(1'b0, nvspi_pkg::OP_READ, 16'h2ffe, 4, 1'b0);
        wp_n <= 1'b0;
        one(nvspi_pkg::OP_WREN);
        wrsr(8'h00);
        wp_n <= 1'b1;
        one(nvspi_pkg::OP_WREN);
        wrsr(8'h0c);
        one(nvspi_pkg::OP_WREN);
        wr(16'h3fff, 1);
        rd(1'b0, nvspi_pkg::OP_READ, 16'h3fff, 1, 1'b0);
        one(nvspi_pkg::OP_WREN);
        wrsr(8'h00);
        cmd(1'b0, nvspi_pkg::OP_RDID);
        for (int k = 0; k < 4; k++) begin
            x8(8'h00);
            chk(r, nvspi_pkg::ID_DEFAULT[(2 - k % 3) * 8 +: 8]);
        end
        cl();
        oe_seen = 1'b0;
        cmd(1'b0, 8'hff);
        x8(nvspi_pkg::OP_READ);
        x8(8'h00);
        cl();
        chk(oe_seen, 1'b0);
        one(nvspi_pkg::OP_WREN);
        wr(16'h0200, 2);
        rd(1'b0, nvspi_pkg::OP_READ, 16'h0200, 2, 1'b1);
        one(nvspi_pkg::OP_WREN);
        cmd(1'b0, nvspi_pkg::OP_WRITE);
        x8(8'h02);
        x8(8'h00);
        nv_spi_master_i.xfer(4, ~mem_m[14'h0200], r);
        cl();
        wel_m = 1'b0;
        rd(1'b0, nvspi_pkg::OP_READ, 16'h0200, 1, 1'b0);
        end_sim();
    end
endmodule

`default_nettype wire
